// ==== logic/wwd_defs.svh ====
// Constants for the window watchdog activation and window control block.
// Assumes a single 200 MHz clock and synchronous comparator inputs.
//
// What this block does
// - Undervoltage returns watchdog to initial status
// - Voltage recovery enters power-on reset status
// - Current at activation threshold starts monitoring
// - Current at deactivation threshold stops monitoring
// - Hysteresis keeps monitoring off below activation
// - Enable low disables detection and activation
// - Enable low deactivates watchdog once any running fault time ends
// - Enable high allows current-based activation
// - Enable input reads low when unconnected
// - Monitoring needs enable, current and voltage
// - Trigger rising edge is a trigger event
// - Trigger input reads low when floating
// - Triggers accepted only while monitoring, fault high
// - Combined output is supervisor AND fault
// - Open trigger closes window; closed reopens
// - Missing trigger timeout causes fault
// - Early second trigger causes fault
// - Fault low holds full time, then open
`ifndef WWD_DEFS_SVH
`define WWD_DEFS_SVH

// Time base tick period in ns and derived clock count
`define WWD_TICK_NS        1000
`define WWD_CLK_NS         5
`define WWD_TICK_CYCLES    (`WWD_TICK_NS / `WWD_CLK_NS)

// Window durations in ticks
`define WWD_TRIGGER_TICKS  100
`define WWD_DP_TICKS       20
`define WWD_FAULT_TICKS    50
`define WWD_POR_TICKS      10

`endif

// ==== logic/wwd_pkg.sv ====
// Types for the window watchdog block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package wwd_pkg;
  typedef enum logic [2:0] {
    WWD_IDLE,
    WWD_POR,
    WWD_OPEN,
    WWD_CLOSED,
    WWD_FAULT
  } wwd_state_e;
endpackage
`default_nettype wire

// ==== logic/wwd_tick_if.sv ====
// Interface carrying the time base tick between block modules.
// Assumes one clock domain.
`default_nettype none
interface wwd_tick_if;
  logic run;
  logic tick;
  modport src (input run, output tick);
  modport dst (output run, input tick);
endinterface
`default_nettype wire

// ==== logic/wwd_timebase.sv ====
// Periodic tick standing in for the capacitor charge/discharge time base.
// Assumes the single block clock.
`include "wwd_defs.svh"
`default_nettype none
module wwd_timebase #(
  parameter int TICK_CYCLES = `WWD_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // Tick link
  wwd_tick_if.src   tb
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  logic [CW-1:0] count;
  wire           wrap = (count == CW'(TICK_CYCLES - 1));

  // Count while running, clear when stopped
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count   <= '0;
      tb.tick <= 1'b0;
    end else begin
      count   <= (!tb.run || wrap) ? '0 : count + CW'(1);
      tb.tick <= tb.run && wrap;
    end
  end
endmodule
`default_nettype wire

// ==== logic/wwd_core.sv ====
// Window watchdog activation control and window state machine.
// Assumes all inputs synchronous to clock; pull-downs are pad cells.
`include "wwd_defs.svh"
`default_nettype none
module wwd_core #(
  parameter int TRIGGER_TICKS = `WWD_TRIGGER_TICKS,
  parameter int DP_TICKS      = `WWD_DP_TICKS,
  parameter int FAULT_TICKS   = `WWD_FAULT_TICKS,
  parameter int POR_TICKS     = `WWD_POR_TICKS,
  parameter int TICK_CYCLES   = `WWD_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // Comparator and pin inputs
  input  wire logic voltage_above_release,
  input  wire logic voltage_below_detect,
  input  wire logic current_above_activate,
  input  wire logic current_below_deactivate,
  input  wire logic watchdog_enable,
  input  wire logic trigger_in,
  input  wire logic supervisor_reset_out_n,
  // Outputs
  output logic      fault_out_n,
  output logic      combined_fault_reset_out_n,
  output logic      monitoring_active,
  output logic      voltage_ok,
  output logic      trigger_seen
);
  ////////////////////////////////////////////////////////////////////////
  localparam int TW = 16;
  wwd_pkg::wwd_state_e state;
  wwd_pkg::wwd_state_e next_state;
  logic [TW-1:0] ticks;
  logic [TW-1:0] next_ticks;
  logic s_rel, s_det, s_act, s_deact, s_en, s_trig, trig_d;
  logic current_on;

  wwd_tick_if tb ();
  wwd_timebase #(.TICK_CYCLES(TICK_CYCLES)) u_tb (
    .clock   (clock),
    .reset_n (reset_n),
    .tb      (tb)
  );

  ////////////////////////////////////////////////////////////////////////
  // Input sampling stage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_rel   <= 1'b0;
      s_det   <= 1'b1;
      s_act   <= 1'b0;
      s_deact <= 1'b1;
      s_en    <= 1'b0;
      s_trig  <= 1'b0;
      trig_d  <= 1'b0;
    end else begin
      s_rel   <= voltage_above_release;
      s_det   <= voltage_below_detect;
      s_act   <= current_above_activate;
      s_deact <= current_below_deactivate;
      s_en    <= watchdog_enable;
      s_trig  <= trigger_in;
      trig_d  <= s_trig;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Voltage status with hysteresis between detect and release
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      voltage_ok <= 1'b0;
    end else if (s_det) begin
      voltage_ok <= 1'b0;
    end else if (s_rel) begin
      voltage_ok <= 1'b1;
    end
  end

  // Current detection latch, held off while disabled
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      current_on <= 1'b0;
    end else if (!s_en) begin
      current_on <= 1'b0;
    end else if (s_act) begin
      current_on <= 1'b1;
    end else if (s_deact) begin
      current_on <= 1'b0;
    end
    // Otherwise hold: stays off until activation level
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoded conditions
  wire mon_req   = s_en && current_on && voltage_ok;
  wire trig_edge = s_trig && !trig_d;
  wire in_win    = (state == wwd_pkg::WWD_OPEN) ||
                   (state == wwd_pkg::WWD_CLOSED);
  wire trig_ok   = trig_edge && in_win && mon_req && fault_out_n;
  wire tick      = tb.tick;
  wire [TW-1:0] ticks_inc = ticks + TW'(1);

  assign tb.run = (state != wwd_pkg::WWD_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Window state machine
  always_comb begin
    next_state = state;
    next_ticks = tick ? ticks_inc : ticks;
    case (state)
      wwd_pkg::WWD_IDLE: begin
        next_ticks = '0;
        if (voltage_ok) begin
          next_state = wwd_pkg::WWD_POR;
        end
      end
      wwd_pkg::WWD_POR: begin
        if (!mon_req) begin
          next_ticks = '0;
        end else if (tick && ticks_inc >= TW'(POR_TICKS)) begin
          next_state = wwd_pkg::WWD_OPEN;
          next_ticks = '0;
        end
      end
      wwd_pkg::WWD_OPEN: begin
        if (!mon_req) begin
          next_state = wwd_pkg::WWD_POR;
          next_ticks = '0;
        end else if (trig_ok) begin
          next_state = wwd_pkg::WWD_CLOSED;
          next_ticks = '0;
        end else if (tick && ticks_inc >= TW'(TRIGGER_TICKS)) begin
          next_state = wwd_pkg::WWD_FAULT;
          next_ticks = '0;
        end
      end
      wwd_pkg::WWD_CLOSED: begin
        if (!mon_req) begin
          next_state = wwd_pkg::WWD_POR;
          next_ticks = '0;
        end else if (trig_ok) begin
          next_state = wwd_pkg::WWD_FAULT;
          next_ticks = '0;
        end else if (tick && ticks_inc >= TW'(DP_TICKS)) begin
          next_state = wwd_pkg::WWD_OPEN;
          next_ticks = '0;
        end
      end
      wwd_pkg::WWD_FAULT: begin
        if (tick && ticks_inc >= TW'(FAULT_TICKS)) begin
          next_state = wwd_pkg::WWD_OPEN;
          next_ticks = '0;
        end
      end
      default: begin
        next_state = wwd_pkg::WWD_IDLE;
        next_ticks = '0;
      end
    endcase
    // Undervoltage overrides everything
    if (!voltage_ok) begin
      next_state = wwd_pkg::WWD_IDLE;
      next_ticks = '0;
    end
  end

  // State register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= wwd_pkg::WWD_IDLE;
      ticks <= '0;
    end else begin
      state <= next_state;
      ticks <= next_ticks;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fault_out_n                <= 1'b1;
      combined_fault_reset_out_n <= 1'b0;
      monitoring_active          <= 1'b0;
      trigger_seen               <= 1'b0;
    end else begin
      fault_out_n <= (next_state != wwd_pkg::WWD_FAULT);
      combined_fault_reset_out_n <= supervisor_reset_out_n &&
        (next_state != wwd_pkg::WWD_FAULT);
      monitoring_active <= mon_req;
      trigger_seen      <= trig_ok;
    end
  end
endmodule
`default_nettype wire

// ==== verification/wwd_core_chk.sv ====
// Port checker for the watchdog core.
// Assumes it is bound into wwd_core.
`default_nettype none
module wwd_core_chk #(
  parameter int FAULT_TICKS = 5,
  parameter int TICK_CYCLES = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Comparator and pin inputs
  input wire logic voltage_above_release,
  input wire logic voltage_below_detect,
  input wire logic current_above_activate,
  input wire logic current_below_deactivate,
  input wire logic watchdog_enable,
  input wire logic trigger_in,
  input wire logic supervisor_reset_out_n,
  // Outputs of the core
  input wire logic fault_out_n,
  input wire logic combined_fault_reset_out_n,
  input wire logic monitoring_active,
  input wire logic voltage_ok,
  input wire logic trigger_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FMAX = FAULT_TICKS * TICK_CYCLES + TICK_CYCLES + 8;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////
  // Combined output follows both sources
  comb_low_a: assert property (!(supervisor_reset_out_n && fault_out_n)
    [*3] |-> !combined_fault_reset_out_n) else $error("combined high");
  comb_high_a: assert property ((supervisor_reset_out_n && fault_out_n)
    [*3] |-> combined_fault_reset_out_n) else $error("combined low");
  // Activation conditions
  en_off_a: assert property (!watchdog_enable [*4] |-> !monitoring_active)
    else $error("monitoring while disabled");
  uv_off_a: assert property (voltage_below_detect [*4] |->
    !voltage_ok && !monitoring_active) else $error("undervoltage ignored");
  mon_on_a: assert property ((watchdog_enable && current_above_activate &&
    voltage_ok) [*4] |-> monitoring_active) else $error("no monitoring");
  // Fault pulse length
  fault_hold_a: assert property ($fell(fault_out_n) ##0
    !voltage_below_detect [*8] |-> !fault_out_n) else $error("fault short");
  fault_end_a: assert property ($fell(fault_out_n) |-> ##[1:FMAX]
    fault_out_n) else $error("fault stuck low");
  // Trigger acceptance
  trig_pulse_a: assert property (trigger_seen |=> !trigger_seen)
    else $error("trigger pulse too long");
  trig_gate_a: assert property (!monitoring_active [*5] |-> !trigger_seen)
    else $error("trigger taken while idle");
endmodule
bind wwd_core wwd_core_chk #(
  .FAULT_TICKS (FAULT_TICKS),
  .TICK_CYCLES (TICK_CYCLES)
) chk_u (
  .clock                      (clock),
  .reset_n                    (reset_n),
  .voltage_above_release      (voltage_above_release),
  .voltage_below_detect       (voltage_below_detect),
  .current_above_activate     (current_above_activate),
  .current_below_deactivate   (current_below_deactivate),
  .watchdog_enable            (watchdog_enable),
  .trigger_in                 (trigger_in),
  .supervisor_reset_out_n     (supervisor_reset_out_n),
  .fault_out_n                (fault_out_n),
  .combined_fault_reset_out_n (combined_fault_reset_out_n),
  .monitoring_active          (monitoring_active),
  .voltage_ok                 (voltage_ok),
  .trigger_seen               (trigger_seen)
);
`default_nettype wire

// ==== verification/wwd_mcu_model.sv ====
// Model of the supervised controller driving trigger and enable pins.
// Assumes callers invoke its tasks from the bench between edges.
`default_nettype none
module wwd_mcu_model (
  input  wire logic clock,
  output var  logic trigger_in,
  output var  logic watchdog_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  initial trigger_in = 1'b0;
  initial watchdog_enable = 1'b0;
  // Rising edge held one cycle, launched off the falling edge
  task automatic pulse;
    @(negedge clock);
    trigger_in = 1'b1;
    @(negedge clock);
    trigger_in = 1'b0;
  endtask
  // Enable pin level
  task automatic set_en(input logic v);
    @(negedge clock);
    watchdog_enable = v;
  endtask
endmodule
`default_nettype wire

// ==== verification/test_window_watchdog_activation_control.sv ====
// Self-checking bench for the watchdog core.
// Assumes a two-clock tick; inputs change on the falling edge.
`default_nettype none
module test_window_watchdog_activation_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, reset_n = 1'b0, sup_n = 1'b1;
  logic rel = 1'b0, det = 1'b0, act = 1'b0, deact = 1'b0;
  wire logic trig, en, fault_n, comb_n, mon, v_ok, seen;
  int errors, num_checks;
  always #2.5 clock = ~clock;
  wwd_core #(.TICK_CYCLES(2)) dut_u (.clock(clock),
    .reset_n(reset_n), .voltage_above_release(rel),
    .voltage_below_detect(det), .current_above_activate(act),
    .current_below_deactivate(deact), .watchdog_enable(en),
    .trigger_in(trig), .supervisor_reset_out_n(sup_n),
    .fault_out_n(fault_n), .combined_fault_reset_out_n(comb_n),
    .monitoring_active(mon), .voltage_ok(v_ok), .trigger_seen(seen));
  wwd_mcu_model mcu_u (.clock(clock), .trigger_in(trig),
    .watchdog_enable(en));
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic drv(input logic [3:0] v, input int n);
    @(negedge clock);
    {rel, det, act, deact} = v;
    cyc(n);
  endtask
  task automatic wait_flt(input logic v, input int n);
    for (int i = 0; i < n && fault_n !== v; i++) @(negedge clock);
    cmp("fault_out_n", v, fault_n);
  endtask
  task automatic wait_seen(input logic e, input int n);
    logic s;
    s = 1'b0;
    for (int i = 0; i < n && !s; i++) begin
      @(negedge clock);
      s = (seen === 1'b1);
    end
    cmp("trigger_seen", e, s);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Triggers in open window pass, early second one faults
  task automatic t_window;
    cyc(20);
    mcu_u.pulse();
    wait_seen(1'b1, 8);
    cyc(40);
    mcu_u.pulse();
    wait_seen(1'b1, 8);
    cmp("fault_out_n", 1'b1, fault_n);
    mcu_u.pulse();
    wait_flt(1'b0, 10);
    mcu_u.pulse();
    wait_seen(1'b0, 4);
    cmp("fault_out_n", 1'b0, fault_n);
    cmp("combined", 1'b0, comb_n);
    wait_flt(1'b1, 110);
  endtask
  // Silence leads to timeout fault
  task automatic t_timeout;
    cyc(180);
    cmp("fault_out_n", 1'b1, fault_n);
    wait_flt(1'b0, 30);
    wait_flt(1'b1, 110);
  endtask
  // Enable pin gates monitoring and trigger acceptance
  task automatic t_enable;
    mcu_u.set_en(1'b0);
    cyc(4);
    cmp("monitoring", 1'b0, mon);
    mcu_u.pulse();
    wait_seen(1'b0, 8);
    mcu_u.set_en(1'b1);
    cyc(4);
    cmp("monitoring", 1'b1, mon);
  endtask
  // Current hysteresis, then undervoltage and recovery
  task automatic t_levels;
    drv(4'h9, 4);
    cmp("monitoring", 1'b0, mon);
    drv(4'h8, 4);
    cmp("monitoring", 1'b0, mon);
    drv(4'ha, 4);
    cmp("monitoring", 1'b1, mon);
    drv(4'h6, 4);
    cmp("voltage_ok", 1'b0, v_ok);
    cmp("monitoring", 1'b0, mon);
    drv(4'h2, 4);
    cmp("voltage_ok", 1'b0, v_ok);
    drv(4'ha, 5);
    cmp("monitoring", 1'b1, mon);
    sup_n = 1'b0;
    cyc(3);
    cmp("combined", 1'b0, comb_n);
    sup_n = 1'b1;
    cyc(3);
    cmp("combined", 1'b1, comb_n);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(5);
    reset_n = 1'b1;
    mcu_u.set_en(1'b1);
    drv(4'ha, 6);
    cmp("monitoring", 1'b1, mon);
    t_window();
    t_timeout();
    t_enable();
    t_levels();
    stop_test();
  end
  initial begin
    #6000;
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
